// ### hdl/pg_mask_regs.vh
// Register offsets, field positions and reset defaults of the power-good mask bank.
`ifndef PG_MASK_REGS_VH
`define PG_MASK_REGS_VH
`define OUTPUT3_RAIL_PG_MASK_OFFSET 8'haa
`define OUTPUT3_MISC_PG_MASK_OFFSET 8'hab
`define SHARED_CONTROL_PIN_PG_MASK_OFFSET 8'hac
`define RAIL_AUX_LDO_TWO_BIT 7
`define RAIL_LOAD_SWITCH_A_ONE_BIT 6
`define RAIL_STEP_DOWN_MSB 5
`define RAIL_STEP_DOWN_LSB 0
`define MISC_CONTROL_INPUT_5_BIT 7
`define MISC_CONTROL_INPUT_4_BIT 6
`define MISC_CONTROL_INPUT_2_BIT 5
`define MISC_CONTROL_INPUT_1_BIT 4
`define MISC_DDR_TERM_BIT 3
`define MISC_SHARED_SRC_BIT 2
`define MISC_LOAD_SWITCH_B_ONE_BIT 1
`define MISC_AUX_LDO_THREE_BIT 0
`define SHARED_OUT1_CONTROL_INPUT_3_BIT 7
`define SHARED_OUT1_CONTROL_INPUT_6_BIT 6
`define SHARED_OUT4_CONTROL_INPUT_3_BIT 5
`define SHARED_OUT4_CONTROL_INPUT_6_BIT 4
`define SHARED_OUT2_CONTROL_INPUT_3_BIT 3
`define SHARED_OUT2_CONTROL_INPUT_6_BIT 2
`define SHARED_OUT3_CONTROL_INPUT_3_BIT 1
`define SHARED_OUT3_CONTROL_INPUT_6_BIT 0
`define MASK_RESET_ALL_IGNORED 8'hff
`endif

// ### hdl/pg_source_sync.v
// Two-flip-flop synchroniser bank for asynchronous power-good and control-pin inputs.
`timescale 1ns/10ps
`default_nettype none
module pg_source_sync #(
	parameter WIDTH = 16
) (
	input wire clock,
	input wire reset,
	input wire [WIDTH-1:0] async_in,
	output reg [WIDTH-1:0] sync_out
);
	reg [WIDTH-1:0] meta_reg;
	genvar i;
	generate
		for (i = 0; i < WIDTH; i = i + 1) begin : g_sync
			always @(posedge clock) begin
				if (reset) begin
					meta_reg[i] <= 1'b0;
					sync_out[i] <= 1'b0;
				end else begin
					meta_reg[i] <= async_in[i];
					sync_out[i] <= meta_reg[i];
				end
			end
		end
	endgenerate
endmodule // pg_source_sync
`default_nettype wire

// ### hdl/power_good_mask_aggregator.v
// Mask register bank and power-good tree for the third power-good output.
`timescale 1ns/10ps
`default_nettype none
`include "pg_mask_regs.vh"

// Function
// RULE1: Output good only when all unmasked sources good.
// RULE2: Rail mask bit 7 gates aux_ldo_two.
// RULE3: Rail mask bit 6 gates load_switch_a_one.
// RULE4: Rail mask bits 5..0 gate step-down rails.
// RULE5: Misc mask bits 7..4 gate control inputs.
// RULE6: Misc mask bit 3 gates termination LDO.
// RULE7: Misc mask bit 2 gates variant-chosen shared source.
// RULE8: Misc mask bit 1 gates load_switch_b_one.
// RULE9: Misc mask bit 0 gates aux_ldo_three.
// RULE10: Shared register holds control_input_3/6 masks per output.
// RULE11: Shared mask zero includes, one excludes input.
// RULE12: Masks read-write; resets from factory programming.
module power_good_mask_aggregator #(
	parameter [7:0] RAIL_MASK_RESET = `MASK_RESET_ALL_IGNORED,
	parameter [7:0] MISC_MASK_RESET = `MASK_RESET_ALL_IGNORED,
	parameter [7:0] SHARED_MASK_RESET = `MASK_RESET_ALL_IGNORED
) (
	input wire clock,
	input wire reset,
	input wire reg_write,
	input wire reg_read,
	input wire [7:0] reg_addr,
	input wire [7:0] reg_wdata,
	output reg [7:0] reg_rdata,
	input wire [5:0] step_down_rail_pg,
	input wire load_switch_a_one_pg,
	input wire aux_ldo_two_pg,
	input wire aux_ldo_three_pg,
	input wire load_switch_b_one_pg,
	input wire shared_switch_or_ldo_pg,
	input wire ddr_termination_ldo_pg,
	input wire [6:1] control_input,
	output reg pg_output_three,
	output reg [7:0] shared_control_pin_mask_out
);
	// Tree positions follow the mask bits, so a source and its mask share one index.
	localparam SOURCE_COUNT = 18;
	localparam MISC_BASE = 8;
	localparam CONTROL_INPUT_6_INDEX = 16;
	localparam CONTROL_INPUT_3_INDEX = 17;

	reg [7:0] output3_rail_pg_mask_reg;
	reg [7:0] output3_rail_pg_mask_next;
	reg [7:0] output3_misc_pg_mask_reg;
	reg [7:0] output3_misc_pg_mask_next;
	reg [7:0] shared_control_pin_pg_mask_reg;
	reg [7:0] shared_control_pin_pg_mask_next;
	reg [7:0] reg_rdata_next;
	reg pg_output_three_next;
	reg [7:0] shared_control_pin_mask_out_next;
	wire rail_select;
	wire misc_select;
	wire shared_select;
	wire rail_write;
	wire misc_write;
	wire shared_write;
	wire [SOURCE_COUNT-1:0] raw_sources;
	wire [SOURCE_COUNT-1:0] good_sync;
	wire [SOURCE_COUNT-1:0] mask_vector;
	wire [SOURCE_COUNT-1:0] source_term;
	wire tree_good;

	assign rail_select = (reg_addr == `OUTPUT3_RAIL_PG_MASK_OFFSET);
	assign misc_select = (reg_addr == `OUTPUT3_MISC_PG_MASK_OFFSET);
	assign shared_select = (reg_addr == `SHARED_CONTROL_PIN_PG_MASK_OFFSET);
	assign rail_write = reg_write & rail_select;
	assign misc_write = reg_write & misc_select;
	assign shared_write = reg_write & shared_select;

	// Each pin lands on the index of the mask bit that gates it.
	assign raw_sources[`RAIL_STEP_DOWN_MSB:`RAIL_STEP_DOWN_LSB] = step_down_rail_pg; // RULE4
	assign raw_sources[`RAIL_LOAD_SWITCH_A_ONE_BIT] = load_switch_a_one_pg; // RULE3
	assign raw_sources[`RAIL_AUX_LDO_TWO_BIT] = aux_ldo_two_pg; // RULE2
	assign raw_sources[MISC_BASE + `MISC_AUX_LDO_THREE_BIT] = aux_ldo_three_pg; // RULE9
	assign raw_sources[MISC_BASE + `MISC_LOAD_SWITCH_B_ONE_BIT] = load_switch_b_one_pg; // RULE8
	assign raw_sources[MISC_BASE + `MISC_SHARED_SRC_BIT] = shared_switch_or_ldo_pg; // RULE7
	assign raw_sources[MISC_BASE + `MISC_DDR_TERM_BIT] = ddr_termination_ldo_pg; // RULE6
	assign raw_sources[MISC_BASE + `MISC_CONTROL_INPUT_1_BIT] = control_input[1]; // RULE5
	assign raw_sources[MISC_BASE + `MISC_CONTROL_INPUT_2_BIT] = control_input[2]; // RULE5
	assign raw_sources[MISC_BASE + `MISC_CONTROL_INPUT_4_BIT] = control_input[4]; // RULE5
	assign raw_sources[MISC_BASE + `MISC_CONTROL_INPUT_5_BIT] = control_input[5]; // RULE5
	assign raw_sources[CONTROL_INPUT_6_INDEX] = control_input[6]; // RULE10
	assign raw_sources[CONTROL_INPUT_3_INDEX] = control_input[3]; // RULE10

	// Pins arrive from other domains, so every source is synchronised before the tree.
	pg_source_sync #(
		.WIDTH(SOURCE_COUNT)
	) u_sync (
		.clock(clock),
		.reset(reset),
		.async_in(raw_sources),
		.sync_out(good_sync)
	);

	assign mask_vector[`RAIL_STEP_DOWN_MSB:`RAIL_STEP_DOWN_LSB] =
		output3_rail_pg_mask_reg[`RAIL_STEP_DOWN_MSB:`RAIL_STEP_DOWN_LSB]; // RULE4
	assign mask_vector[`RAIL_LOAD_SWITCH_A_ONE_BIT] =
		output3_rail_pg_mask_reg[`RAIL_LOAD_SWITCH_A_ONE_BIT]; // RULE3
	assign mask_vector[`RAIL_AUX_LDO_TWO_BIT] =
		output3_rail_pg_mask_reg[`RAIL_AUX_LDO_TWO_BIT]; // RULE2
	assign mask_vector[MISC_BASE + `MISC_AUX_LDO_THREE_BIT] =
		output3_misc_pg_mask_reg[`MISC_AUX_LDO_THREE_BIT]; // RULE9
	assign mask_vector[MISC_BASE + `MISC_LOAD_SWITCH_B_ONE_BIT] =
		output3_misc_pg_mask_reg[`MISC_LOAD_SWITCH_B_ONE_BIT]; // RULE8
	assign mask_vector[MISC_BASE + `MISC_SHARED_SRC_BIT] =
		output3_misc_pg_mask_reg[`MISC_SHARED_SRC_BIT]; // RULE7
	assign mask_vector[MISC_BASE + `MISC_DDR_TERM_BIT] =
		output3_misc_pg_mask_reg[`MISC_DDR_TERM_BIT]; // RULE6
	assign mask_vector[MISC_BASE + `MISC_CONTROL_INPUT_1_BIT] =
		output3_misc_pg_mask_reg[`MISC_CONTROL_INPUT_1_BIT]; // RULE5
	assign mask_vector[MISC_BASE + `MISC_CONTROL_INPUT_2_BIT] =
		output3_misc_pg_mask_reg[`MISC_CONTROL_INPUT_2_BIT]; // RULE5
	assign mask_vector[MISC_BASE + `MISC_CONTROL_INPUT_4_BIT] =
		output3_misc_pg_mask_reg[`MISC_CONTROL_INPUT_4_BIT]; // RULE5
	assign mask_vector[MISC_BASE + `MISC_CONTROL_INPUT_5_BIT] =
		output3_misc_pg_mask_reg[`MISC_CONTROL_INPUT_5_BIT]; // RULE5
	assign mask_vector[CONTROL_INPUT_6_INDEX] =
		shared_control_pin_pg_mask_reg[`SHARED_OUT3_CONTROL_INPUT_6_BIT]; // RULE11
	assign mask_vector[CONTROL_INPUT_3_INDEX] =
		shared_control_pin_pg_mask_reg[`SHARED_OUT3_CONTROL_INPUT_3_BIT]; // RULE11

	// A set mask bit forces its term true, so a masked source can never pull the output low.
	genvar i;
	generate
		for (i = 0; i < SOURCE_COUNT; i = i + 1) begin : g_term
			assign source_term[i] = good_sync[i] | mask_vector[i]; // RULE1
		end
	endgenerate
	assign tree_good = &source_term; // RULE1

	always @* begin
		output3_rail_pg_mask_next = output3_rail_pg_mask_reg;
		output3_misc_pg_mask_next = output3_misc_pg_mask_reg;
		shared_control_pin_pg_mask_next = shared_control_pin_pg_mask_reg;
		if (rail_write) begin
			output3_rail_pg_mask_next = reg_wdata; // RULE12
		end
		if (misc_write) begin
			output3_misc_pg_mask_next = reg_wdata; // RULE12
		end
		if (shared_write) begin
			shared_control_pin_pg_mask_next = reg_wdata; // RULE10 RULE12
		end
	end

	// Unmapped offsets read as zero; a read in the cycle of a write returns the old value.
	always @* begin
		reg_rdata_next = reg_rdata;
		if (reg_read) begin
			case (reg_addr)
				`OUTPUT3_RAIL_PG_MASK_OFFSET: begin
					reg_rdata_next = output3_rail_pg_mask_reg; // RULE12
				end
				`OUTPUT3_MISC_PG_MASK_OFFSET: begin
					reg_rdata_next = output3_misc_pg_mask_reg; // RULE12
				end
				`SHARED_CONTROL_PIN_PG_MASK_OFFSET: begin
					reg_rdata_next = shared_control_pin_pg_mask_reg; // RULE12
				end
				default: begin
					reg_rdata_next = 8'h00;
				end
			endcase
		end
	end

	always @* begin
		pg_output_three_next = tree_good; // RULE1
		shared_control_pin_mask_out_next = shared_control_pin_pg_mask_reg; // RULE10
	end

	// Reset loads factory-programmed defaults, which differ per variant, hence parameters.
	always @(posedge clock) begin
		if (reset) begin
			output3_rail_pg_mask_reg <= RAIL_MASK_RESET; // RULE12
		end else begin
			output3_rail_pg_mask_reg <= output3_rail_pg_mask_next; // RULE12
		end
	end

	always @(posedge clock) begin
		if (reset) begin
			output3_misc_pg_mask_reg <= MISC_MASK_RESET; // RULE12
		end else begin
			output3_misc_pg_mask_reg <= output3_misc_pg_mask_next; // RULE12
		end
	end

	always @(posedge clock) begin
		if (reset) begin
			shared_control_pin_pg_mask_reg <= SHARED_MASK_RESET; // RULE12
		end else begin
			shared_control_pin_pg_mask_reg <= shared_control_pin_pg_mask_next; // RULE12
		end
	end

	always @(posedge clock) begin
		if (reset) begin
			reg_rdata <= 8'h00;
		end else begin
			reg_rdata <= reg_rdata_next;
		end
	end

	// Output stays low during reset so nothing downstream sees a false good.
	always @(posedge clock) begin
		if (reset) begin
			pg_output_three <= 1'b0;
		end else begin
			pg_output_three <= pg_output_three_next; // RULE1
		end
	end

	always @(posedge clock) begin
		if (reset) begin
			shared_control_pin_mask_out <= SHARED_MASK_RESET;
		end else begin
			shared_control_pin_mask_out <= shared_control_pin_mask_out_next; // RULE10
		end
	end
endmodule // power_good_mask_aggregator
`default_nettype wire

// ### bench/pg_props_properties.sv
// Port checks for the power-good mask bank.
`timescale 1ns/10ps
`default_nettype none
module pg_props (
	input wire logic clock,
	input wire logic reset,
	input wire logic reg_write,
	input wire logic reg_read,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic [7:0] reg_rdata,
	input wire logic [6:1] control_input,
	input wire logic pg_output_three,
	input wire logic [7:0] shared_control_pin_mask_out
);
	default clocking @(posedge clock); endclocking
	default disable iff (reset);
	// The pin needs three edges to reach the output, and the mask copy on the port lags the
	// mask that the tree uses by one edge, so the mask is checked at the output's edge too.
	property p_control_input_6; (!shared_control_pin_mask_out[0] && !control_input[6])[*3]
		##1 !shared_control_pin_mask_out[0] |-> !pg_output_three;
	endproperty
	a_control_input_6: assert property (p_control_input_6) else $error("control_input_6 ignored");
	property p_control_input_3; (!shared_control_pin_mask_out[1] && !control_input[3])[*3]
		##1 !shared_control_pin_mask_out[1] |-> !pg_output_three;
	endproperty
	a_control_input_3: assert property (p_control_input_3) else $error("control_input_3 ignored");
	// The port copy follows a write to the shared register two edges later.
	property p_wr; reg_write && reg_addr == 8'hac
		|=> ##1 shared_control_pin_mask_out == $past(reg_wdata, 2);
	endproperty
	a_wr: assert property (p_wr) else $error("shared write lost");
	property p_hold; !(reg_write && reg_addr == 8'hac)
		|=> ##1 $stable(shared_control_pin_mask_out);
	endproperty
	a_hold: assert property (p_hold) else $error("shared mask moved");
	property p_un; reg_read && reg_addr == 8'had |=> reg_rdata == 8'h00;
	endproperty
	a_un: assert property (p_un) else $error("unmapped read");
	property p_rac; reg_read && !reg_write && reg_addr == 8'hac
		|=> reg_rdata == shared_control_pin_mask_out;
	endproperty
	a_rac: assert property (p_rac) else $error("shared read");
	property p_rd; !reg_read |=> $stable(reg_rdata);
	endproperty
	a_rd: assert property (p_rd) else $error("read data moved");
	property p_rb; reg_write && reg_addr == 8'haa
		##1 reg_read && !reg_write && reg_addr == 8'haa |=> reg_rdata == $past(reg_wdata, 2);
	endproperty
	a_rb: assert property (p_rb) else $error("readback");
endmodule // pg_props
bind power_good_mask_aggregator pg_props pg_props_inst (.clock(clock), .reset(reset),
	.reg_write(reg_write), .reg_read(reg_read), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
	.reg_rdata(reg_rdata), .control_input(control_input), .pg_output_three(pg_output_three),
	.shared_control_pin_mask_out(shared_control_pin_mask_out));
`default_nettype wire

// ### bench/pg_host.sv
// Processor-side watcher of the power-good level.
`timescale 1ns/10ps
`default_nettype none
module pg_host (
	input wire logic clock,
	input wire logic pg_in,
	output logic seen_good
);
	// The level is already synchronous, so one sample a clock is enough.
	always @(posedge clock) seen_good <= pg_in;
endmodule // pg_host
`default_nettype wire

// ### bench/tb.sv
// Bench for the power-good mask bank.
`timescale 1ns/10ps
`default_nettype none
module tb;
	logic clock = 0, reset = 1, reg_write = 0, reg_read = 0, pg, seen;
	logic [7:0] reg_addr = 0, reg_wdata = 0, reg_rdata, mask_out;
	logic [17:0] src = 0;
	int error_cnt = 0, check_count = 0;
	always #20 clock = ~clock;
	power_good_mask_aggregator power_good_mask_aggregator_inst (.clock(clock), .reset(reset),
		.reg_write(reg_write), .reg_read(reg_read), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_rdata(reg_rdata), .step_down_rail_pg(src[5:0]), .load_switch_a_one_pg(src[6]),
		.aux_ldo_two_pg(src[7]), .aux_ldo_three_pg(src[8]), .load_switch_b_one_pg(src[9]),
		.shared_switch_or_ldo_pg(src[10]), .ddr_termination_ldo_pg(src[11]),
		.control_input({src[16], src[15], src[14], src[17], src[13], src[12]}),
		.pg_output_three(pg), .shared_control_pin_mask_out(mask_out));
	pg_host pg_host_inst (.clock(clock), .pg_in(pg), .seen_good(seen));
	task chk(input logic [7:0] got, exp);
		check_count++;
		if (got !== exp) begin
			error_cnt++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task acc(input logic w, r, input logic [7:0] a, d);
		{reg_write, reg_read, reg_addr, reg_wdata} = {w, r, a, d};
		@(posedge clock);
		#1;
	endtask
	// Bit k of m masks the source on bit k of s.
	task setm(input logic [17:0] m, s);
		acc(1, 0, 8'haa, m[7:0]);
		acc(1, 0, 8'hab, m[15:8]);
		acc(1, 0, 8'hac, {6'h15, m[17:16]});
		src = s;
		repeat (5) acc(0, 0, 8'h00, 8'h00);
		chk(mask_out, {6'h15, m[17:16]});
	endtask
	task end_sim;
		$display("checks %0d mismatches %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	initial begin
		repeat (4) @(posedge clock);
		#1;
		reset = 0;
		for (int a = 8'haa; a < 8'hae; a++) begin
			acc(0, 1, a[7:0], 8'h00);
			chk(reg_rdata, a == 8'had ? 8'h00 : 8'hff);
		end
		$display("reset values done");
		for (int a = 8'haa; a < 8'hae; a++) begin
			acc(1, 0, a[7:0], a[7:0] ^ 8'h33);
			acc(0, 1, a[7:0], 8'h00);
			chk(reg_rdata, a == 8'had ? 8'h00 : a[7:0] ^ 8'h33);
		end
		$display("readback done");
		for (int k = 0; k < 18; k++) begin
			setm(18'h0, ~(18'h1 << k));
			chk(seen, 1'b0);
			setm(18'h1 << k, ~(18'h1 << k));
			chk(seen, 1'b1);
		end
		setm(18'h3ffff, 18'h0);
		chk(seen, 1'b1);
		$display("tree done");
		end_sim;
	end
	initial begin
		#1000000;
		error_cnt++;
		end_sim;
	end
endmodule // tb
`default_nettype wire
